// ==== crw_map.svh ====
// Register offsets, field positions, reset values and debounce counts
`ifndef CRW_MAP_SVH
`define CRW_MAP_SVH
// ----------------------------------------------------------------
// Byte offsets
// ----------------------------------------------------------------
`define CRW_CONTROL_OFS 8'h00
`define CRW_MONITOR_OFS 8'h04
`define CRW_SUPPLY_OFS 8'h08
`define CRW_WAKEMODE_OFS 8'h0c
`define CRW_WAKEIN_OFS 8'h10
`define CRW_STATUS_OFS 8'h14
`define CRW_PROTECT_OFS 8'h18
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CRW_REG_OFF 2
`define CRW_MON_RST_EN 12
`define CRW_BOD_RST_EN 12
`define CRW_REG_USED 14
`define CRW_FW_EN 0
`define CRW_MON_WAKE_EN 1
`define CRW_INT_WAKE_EN 2
`define CRW_CAL_WAKE_EN 3
`define CRW_FW_DBC_MSB 10
`define CRW_FW_DBC_LSB 8
`define CRW_WI_DBC_MSB 14
`define CRW_WI_DBC_LSB 12
`define CRW_TP_CNT_MSB 19
`define CRW_TP_CNT_LSB 16
`define CRW_TP0_EN 20
`define CRW_TP1_EN 21
`define CRW_TP_CLR 22
`define CRW_TP0_POL 24
`define CRW_TP1_POL 25
`define CRW_WP_EN 0
`define CRW_WI_POL_LSB 16
// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define CRW_MONITOR_RST 32'h0000_0000
`define CRW_SUPPLY_RST 32'h0000_5000
`define CRW_WAKEMODE_RST 32'h0000_0000
`define CRW_MONITOR_MASK 32'h0000_1000
`define CRW_SUPPLY_MASK 32'h0000_5000
`define CRW_WAKEMODE_MASK 32'h037f_770f
// ----------------------------------------------------------------
// Debounce periods in slow clock cycles and tamper sample limits
// ----------------------------------------------------------------
`define CRW_DBC_IMM 16'h0001
`define CRW_DBC_P1 16'h0003
`define CRW_DBC_P2 16'h0020
`define CRW_DBC_P3 16'h0200
`define CRW_DBC_P4 16'h1000
`define CRW_DBC_P5 16'h8000
`define CRW_TP_MIN 4'h2
`define CRW_TP_MAX 4'h8
`endif

// ==== crw_pkg.sv ====
// Types shared by the core reset and wake-up control block
`include "crw_map.svh"
package crw_pkg;
  typedef enum logic [3:0] {
    CRW_WAKEUP = 4'h1,
    CRW_ACTIVE = 4'h2,
    CRW_SHUTDOWN = 4'h4,
    CRW_BACKUP = 4'h8
  } crw_core_type;

  typedef struct packed {
    logic tamper1;
    logic tamper0;
    logic pinLevel;
    logic monitorLive;
    logic monitorReset;
    logic brownout;
    logic monitorWake;
    logic wakeInput;
    logic forceWake;
  } crw_flags_type;

  typedef struct packed {
    logic [15:0] count;
    logic done;
    logic fire;
  } crw_dbc_state_type;

  typedef struct packed {
    logic [3:0] count;
    logic done;
    logic fire;
  } crw_lp_state_type;

  // Debounce select to required count of slow clock cycles
  function automatic logic [15:0] crw_dbc_limit(input logic [2:0] sel);
    if (sel == 3'h0) return `CRW_DBC_IMM;
    else if (sel == 3'h1) return `CRW_DBC_P1;
    else if (sel == 3'h2) return `CRW_DBC_P2;
    else if (sel == 3'h3) return `CRW_DBC_P3;
    else if (sel == 3'h4) return `CRW_DBC_P4;
    else return `CRW_DBC_P5;
  endfunction
endpackage

// ==== crw_debounce.sv ====
// Level debounce counter with restart on an inactive sample
module crw_debounce import crw_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rstN,
  // Qualified level and period select
  input wire logic active,
  input wire logic [2:0] sel,
  // One-cycle event
  output logic fire
);
  crw_dbc_state_type s, next_s;
  logic [15:0] inc;

  always_comb begin
    next_s = s;
    inc = s.count + 16'h0001;
    next_s.fire = 1'b0;
    if (!active) begin
      next_s.count = 16'h0000;
      next_s.done = 1'b0;
    end else if (!s.done) begin
      next_s.count = inc;
      if (inc >= crw_dbc_limit(sel)) begin
        next_s.fire = 1'b1;
        next_s.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) s <= '0;
    else s <= next_s;
  end

  assign fire = s.fire;
endmodule // crw_debounce

// ==== crw_lp_debounce.sv ====
// Low-power tamper debouncer counting identical strobed samples
module crw_lp_debounce import crw_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rstN,
  // Sample point, polarity-adjusted input, samples needed
  input wire logic strobe,
  input wire logic active,
  input wire logic [3:0] need,
  // One-cycle tamper event
  output logic fire
);
  crw_lp_state_type s, next_s;
  logic [3:0] inc;

  always_comb begin
    next_s = s;
    inc = s.count + 4'h1;
    next_s.fire = 1'b0;
    if (strobe) begin
      if (!active) begin
        next_s.count = 4'h0;
        next_s.done = 1'b0;
      end else if (!s.done) begin
        next_s.count = inc;
        if (inc >= need) begin
          next_s.fire = 1'b1;
          next_s.done = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) s <= '0;
    else s <= next_s;
  end

  assign fire = s.fire;
endmodule // crw_lp_debounce

// ==== crw_core_reset_wake.sv ====
// Core reset and wake-up control with AHB-Lite register slave
// Contract
// - Reset before supply off, release when regulated
// - Monitor detection resets core, one cycle minimum
// - Brownout over one cycle resets core
// - Brownout reset holds until good returns
// - Flag records brownout as reset source
// - Enabled wake event restarts core supply
// - Force-wake debounce selects 3 to 32768
// - Select zero wakes after one low cycle
// - Force-wake sets flag until status read
// - Per-input enable and polarity, shared counter
// - Wake debounce periods, zero means immediate
// - Latch wake inputs on debounced wake
// - Two tamper debouncers, own enables, always
// - Tamper sampled on pulse falling edge
// - Shared sample count from 2 to 8
// - Each tamper input has own polarity
// - Separate status flag per tamper debouncer
// - Tamper clears first backup registers half
// - Clock alarms wake core, no status
// - Write protect blocks four config registers
// - Read clear acts two cycles later
// - Polarity selects edge then level
module crw_core_reset_wake import crw_pkg::*; #(
  parameter int WAKE_COUNT = 16
) (
  // Slow clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Supply sensing and wake sources
  input wire logic monitorDetect,
  input wire logic brownoutGood,
  input wire logic force_wake_pin_n,
  input wire logic [WAKE_COUNT-1:0] wake_input_n,
  input wire logic calendarAlarm,
  input wire logic intervalAlarm,
  input wire logic calendar_pulse_output,
  // Core supply control
  output logic coreResetN,
  output logic regulatorOn,
  output logic backupClear
);
  typedef struct packed {
    crw_core_type core;
    logic wrPend;
    logic [7:0] wrAddr;
    logic [31:0] rdata;
    logic readyOut;
    logic [1:0] clrPipe;
    logic [31:0] monMode;
    logic [31:0] supMode;
    logic [31:0] wakeMode;
    logic [31:0] wakeInReg;
    logic protect;
    crw_flags_type flags;
    logic [WAKE_COUNT-1:0] latched;
    logic [WAKE_COUNT-1:0] armed;
    logic monHold;
    logic [1:0] bodLow;
    logic bodReset;
    logic bodHeld;
    logic goodSeen;
    logic pulsePrev;
    logic coreResetN;
    logic regOn;
    logic backupClear;
  } crw_state_type;

  crw_state_type s, next_s;
  logic rstMeta, rstN;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rstMeta <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN <= rstMeta;
    end
  end

  // ----------------------------------------------------------------
  // Wake sources
  // ----------------------------------------------------------------
  logic [WAKE_COUNT-1:0] wiActive, wiQual;
  logic [15:0] wiBits;
  logic fwFire, wiFire, tp0Fire, tp1Fire, strobe;
  logic [3:0] tpNeed, tpRaw;

  generate
    for (genvar i = 0; i < WAKE_COUNT; i++) begin : g_wake
      // Active level per polarity bit; armed needs an inactive sample first
      assign wiActive[i] = wake_input_n[i] ~^ s.wakeInReg[`CRW_WI_POL_LSB + i];
      assign wiQual[i] = s.wakeInReg[i] & wiActive[i] & s.armed[i];
    end
  endgenerate

  assign wiBits = 16'(s.latched);
  assign strobe = s.pulsePrev & ~calendar_pulse_output;
  assign tpRaw = s.wakeMode[`CRW_TP_CNT_MSB:`CRW_TP_CNT_LSB];
  assign tpNeed = (tpRaw < `CRW_TP_MIN) ? `CRW_TP_MIN :
                  (tpRaw > `CRW_TP_MAX) ? `CRW_TP_MAX : tpRaw;

  crw_debounce u_force (
    .clk(ref_clk),
    .rstN(rstN),
    .active(s.wakeMode[`CRW_FW_EN] & ~force_wake_pin_n),
    .sel(s.wakeMode[`CRW_FW_DBC_MSB:`CRW_FW_DBC_LSB]),
    .fire(fwFire)
  );

  crw_debounce u_inputs (
    .clk(ref_clk),
    .rstN(rstN),
    .active(|wiQual),
    .sel(s.wakeMode[`CRW_WI_DBC_MSB:`CRW_WI_DBC_LSB]),
    .fire(wiFire)
  );

  // Tampers run in every core state; inputs 0 and 1 are shared pins
  crw_lp_debounce u_tamper0 (
    .clk(ref_clk),
    .rstN(rstN),
    .strobe(strobe),
    .active(s.wakeMode[`CRW_TP0_EN]
            & (wake_input_n[0] ~^ s.wakeMode[`CRW_TP0_POL])),
    .need(tpNeed),
    .fire(tp0Fire)
  );

  crw_lp_debounce u_tamper1 (
    .clk(ref_clk),
    .rstN(rstN),
    .strobe(strobe),
    .active(s.wakeMode[`CRW_TP1_EN]
            & (wake_input_n[1] ~^ s.wakeMode[`CRW_TP1_POL])),
    .need(tpNeed),
    .fire(tp1Fire)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic addrPhase, wrAllowed, monTrig, bodTrig, monWake, wakeAny;
  logic vroffReq, clearNow;
  logic [31:0] wd;

  always_comb begin
    next_s = s;
    wd = hwdata;
    clearNow = s.clrPipe[1];
    addrPhase = hsel & htrans[1] & hready;
    wrAllowed = s.wrPend & ~s.protect;
    vroffReq = 1'b0;

    // Data phase of a write
    if (s.wrPend) begin
      if (s.wrAddr == `CRW_PROTECT_OFS) begin
        next_s.protect = wd[`CRW_WP_EN];
      end else if (s.wrAddr == `CRW_WAKEIN_OFS) begin
        next_s.wakeInReg = wd;
      end else if (!wrAllowed) begin
        next_s.protect = s.protect;
      end else if (s.wrAddr == `CRW_CONTROL_OFS) begin
        vroffReq = wd[`CRW_REG_OFF];
      end else if (s.wrAddr == `CRW_MONITOR_OFS) begin
        next_s.monMode = wd & `CRW_MONITOR_MASK;
      end else if (s.wrAddr == `CRW_SUPPLY_OFS) begin
        next_s.supMode = wd & `CRW_SUPPLY_MASK;
      end else if (s.wrAddr == `CRW_WAKEMODE_OFS) begin
        next_s.wakeMode = wd & `CRW_WAKEMODE_MASK;
      end
    end

    // Supply monitor reset
    monTrig = s.monMode[`CRW_MON_RST_EN] & monitorDetect & (s.core == CRW_ACTIVE);
    next_s.monHold = monTrig;

    // Brownout loss over more than one cycle
    if (s.regOn && s.supMode[`CRW_REG_USED] && !brownoutGood) begin
      next_s.bodLow = (s.bodLow == 2'h2) ? 2'h2 : s.bodLow + 2'h1;
    end else begin
      next_s.bodLow = 2'h0;
    end
    bodTrig = s.supMode[`CRW_BOD_RST_EN] & (s.bodLow != 2'h0) & ~brownoutGood
              & s.regOn & s.supMode[`CRW_REG_USED] & ~s.bodReset;
    next_s.bodReset = bodTrig | (s.bodReset & ~(brownoutGood & s.bodHeld));
    next_s.bodHeld = s.bodReset;

    // Wake decision
    monWake = s.wakeMode[`CRW_MON_WAKE_EN] & monitorDetect;
    wakeAny = fwFire | wiFire | tp0Fire | tp1Fire | monWake
              | (s.wakeMode[`CRW_CAL_WAKE_EN] & calendarAlarm)
              | (s.wakeMode[`CRW_INT_WAKE_EN] & intervalAlarm);

    next_s.armed = (wiFire ? '0 : s.armed) | ~wiActive;
    next_s.pulsePrev = calendar_pulse_output;
    next_s.goodSeen = brownoutGood;

    // Core supply sequencing
    case (s.core)
      CRW_WAKEUP: begin
        next_s.regOn = 1'b1;
        // Regulated once good is seen on two edges in a row
        if ((brownoutGood && s.goodSeen) || !s.supMode[`CRW_REG_USED]) begin
          next_s.core = CRW_ACTIVE;
        end
      end
      CRW_ACTIVE: begin
        if (vroffReq) next_s.core = CRW_SHUTDOWN;
      end
      CRW_SHUTDOWN: begin
        // Reset is already low here, one cycle before supply drops
        next_s.regOn = 1'b0;
        next_s.core = CRW_BACKUP;
      end
      CRW_BACKUP: begin
        if (wakeAny) next_s.core = CRW_WAKEUP;
      end
      default: next_s.core = CRW_WAKEUP;
    endcase

    next_s.coreResetN = (next_s.core == CRW_ACTIVE) & (s.core == CRW_ACTIVE
                        || s.core == CRW_WAKEUP) & ~monTrig & ~s.monHold
                        & ~bodTrig & ~next_s.bodReset;
    next_s.backupClear = s.wakeMode[`CRW_TP_CLR] & (tp0Fire | tp1Fire);

    // Status: read clear two cycles late, a new set wins
    next_s.clrPipe = {s.clrPipe[0], 1'b0};
    if (clearNow) begin
      next_s.flags.forceWake = 1'b0;
      next_s.flags.wakeInput = 1'b0;
      next_s.flags.monitorWake = 1'b0;
      next_s.flags.brownout = 1'b0;
      next_s.flags.monitorReset = 1'b0;
      next_s.flags.tamper0 = 1'b0;
      next_s.flags.tamper1 = 1'b0;
    end
    if (fwFire) next_s.flags.forceWake = 1'b1;
    if (wiFire) begin
      next_s.flags.wakeInput = 1'b1;
      next_s.latched = ~wiActive ^ {WAKE_COUNT{1'b1}};
    end
    if (monWake && s.core == CRW_BACKUP) next_s.flags.monitorWake = 1'b1;
    if (bodTrig) next_s.flags.brownout = 1'b1;
    if (monTrig) begin
      next_s.flags.monitorReset = 1'b1;
      next_s.flags.brownout = bodTrig;
    end
    if (tp0Fire) next_s.flags.tamper0 = 1'b1;
    if (tp1Fire) next_s.flags.tamper1 = 1'b1;
    next_s.flags.monitorLive = monitorDetect;
    next_s.flags.pinLevel = force_wake_pin_n;

    // Address phase; read data except status comes from the updated copy
    next_s.wrPend = addrPhase & hwrite;
    next_s.wrAddr = haddr;
    next_s.readyOut = 1'b1;
    if (addrPhase && !hwrite) begin
      if (haddr == `CRW_CONTROL_OFS) begin
        next_s.rdata = 32'h0000_0000;
      end else if (haddr == `CRW_MONITOR_OFS) begin
        next_s.rdata = next_s.monMode;
      end else if (haddr == `CRW_SUPPLY_OFS) begin
        next_s.rdata = next_s.supMode;
      end else if (haddr == `CRW_WAKEMODE_OFS) begin
        next_s.rdata = next_s.wakeMode;
      end else if (haddr == `CRW_WAKEIN_OFS) begin
        next_s.rdata = next_s.wakeInReg;
      end else if (haddr == `CRW_STATUS_OFS) begin
        next_s.rdata = {wiBits, 7'h00, s.flags};
        next_s.clrPipe[0] = 1'b1;
      end else if (haddr == `CRW_PROTECT_OFS) begin
        next_s.rdata = {31'h0, next_s.protect};
      end else begin
        next_s.rdata = 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      s <= '0;
      s.core <= CRW_WAKEUP;
      s.readyOut <= 1'b1;
      s.regOn <= 1'b1;
      s.monMode <= `CRW_MONITOR_RST;
      s.supMode <= `CRW_SUPPLY_RST;
      s.wakeMode <= `CRW_WAKEMODE_RST;
    end else begin
      s <= next_s;
    end
  end

  assign hrdata = s.rdata;
  assign hreadyout = s.readyOut;
  assign hresp = 1'b0;
  assign coreResetN = s.coreResetN;
  assign regulatorOn = s.regOn;
  assign backupClear = s.backupClear;
endmodule // crw_core_reset_wake

// ==== crw_core_reset_wake_props.sv ====
// Port-level checks for the core reset and wake-up block
module crw_core_reset_wake_props (
  // Clock, reset and bus
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // Supply and wake
  input wire logic monitorDetect,
  input wire logic brownoutGood,
  input wire logic force_wake_pin_n,
  input wire logic coreResetN,
  input wire logic regulatorOn,
  input wire logic backupClear
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wrPend;
  logic protect;
  logic monRstEn;
  logic bodArm;
  logic fwFast;
  logic [7:0] wrAddr;
  // ----------------------------------------------------------------
  // Shadow of the enables, since only the ports are visible here
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
      protect <= 1'b0;
      monRstEn <= 1'b0;
      bodArm <= 1'b1;
      fwFast <= 1'b0;
    end else begin
      wrPend <= hsel && htrans[1] && hready && hwrite;
      wrAddr <= haddr;
      if (wrPend && wrAddr == 8'h18)
        protect <= hwdata[0];
      if (wrPend && !protect && wrAddr == 8'h04)
        monRstEn <= hwdata[12];
      if (wrPend && !protect && wrAddr == 8'h08)
        bodArm <= hwdata[12] && hwdata[14];
      if (wrPend && !protect && wrAddr == 8'h0c)
        fwFast <= hwdata[0] && hwdata[10:8] == 3'h0;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_good_lost;
    (bodArm && regulatorOn && coreResetN && !brownoutGood) [*2];
  endsequence
  sequence s_held_low;
    !coreResetN ##1 !coreResetN;
  endsequence
  a_off_after_reset: assert property (
    $fell(regulatorOn) |-> !coreResetN && !$past(coreResetN)) else $error("supply off without reset");
  a_on_under_reset: assert property (
    $rose(regulatorOn) |-> s_held_low) else $error("supply restart without reset");
  a_release_regulated: assert property (
    $rose(coreResetN) |-> regulatorOn) else $error("reset released without regulator");
  a_monitor_reset: assert property (
    monRstEn && monitorDetect && coreResetN |-> ##[1:2] !coreResetN) else $error("no monitor reset");
  a_reset_min_one: assert property (
    $fell(coreResetN) |=> !coreResetN) else $error("core reset too short");
  a_brownout_reset: assert property (
    s_good_lost |=> !coreResetN) else $error("no brownout reset");
  a_brownout_hold: assert property (
    bodArm && regulatorOn && !coreResetN && !brownoutGood |=> !coreResetN)
    else $error("reset released while supply bad");
  a_force_wake_fast: assert property (
    fwFast && !regulatorOn && !force_wake_pin_n |-> ##[1:6] regulatorOn) else $error("no fast wake");
  a_clear_pulse: assert property (
    backupClear |=> !backupClear) else $error("backup clear longer than one cycle");
endmodule // crw_core_reset_wake_props

bind crw_core_reset_wake crw_core_reset_wake_props u_props (
  .ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .monitorDetect(monitorDetect),
  .brownoutGood(brownoutGood), .force_wake_pin_n(force_wake_pin_n),
  .coreResetN(coreResetN), .regulatorOn(regulatorOn), .backupClear(backupClear)
);

// ==== crw_far_model.sv ====
// Far-side model: core supply good indication and tamper sampling waveform
module crw_far_model (
  // Clock and core supply
  input wire logic ref_clk,
  input wire logic regulatorOn,
  // Bench commands
  input wire logic dropGood,
  input wire logic pulseRun,
  // Supply good and sampling waveform
  output logic brownoutGood,
  output logic calendar_pulse_output
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] rampUp = 3'h0;
  logic [1:0] phase = 2'h0;
  // Regulation settles three cycles after turn-on, and is lost one cycle after turn-off
  always @(posedge ref_clk) begin
    rampUp <= {rampUp[1:0], regulatorOn};
    phase <= pulseRun ? phase + 2'h1 : 2'h0;
  end
  assign brownoutGood = &rampUp && !dropGood;
  // Falls every four cycles; stands low between frames
  assign calendar_pulse_output = phase[1];
endmodule // crw_far_model

// ==== test_crw_core_reset_wake.sv ====
// Self-checking bench for the core reset and wake-up block
module test_crw_core_reset_wake;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic hready, hreadyout, hresp, coreResetN, regulatorOn, backupClear, brownoutGood, pulseOut;
  logic monitorDetect = 1'b0;
  logic force_wake_pin_n = 1'b1;
  logic calendarAlarm = 1'b0;
  logic intervalAlarm = 1'b0;
  logic dropGood = 1'b0;
  logic pulseRun = 1'b0;
  logic [15:0] wake_input_n = 16'h0004;
  int mismatches = 0;
  int cmp_count = 0;
  int dbc [6] = '{1, 3, 32, 512, 4096, 32768};
  // Outputs settled mid-cycle, so a poll at the rising edge never races the launch
  logic [2:0] seen = 3'h0;
  always @(negedge ref_clk) begin
    seen <= {backupClear, regulatorOn, coreResetN};
  end
  assign hready = hreadyout;
  always #50 ref_clk = ~ref_clk;
  crw_core_reset_wake #(.WAKE_COUNT(16)) dut (
    .ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .monitorDetect(monitorDetect),
    .brownoutGood(brownoutGood), .force_wake_pin_n(force_wake_pin_n),
    .wake_input_n(wake_input_n), .calendarAlarm(calendarAlarm), .intervalAlarm(intervalAlarm),
    .calendar_pulse_output(pulseOut), .coreResetN(coreResetN), .regulatorOn(regulatorOn),
    .backupClear(backupClear));
  crw_far_model far (.ref_clk(ref_clk), .regulatorOn(regulatorOn), .dropGood(dropGood),
    .pulseRun(pulseRun), .brownoutGood(brownoutGood), .calendar_pulse_output(pulseOut));
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hready !== 1'b1 && n < 40);
    q = hrdata;
    check({31'h0, hready}, 32'h1);
    check({31'h0, hresp}, 32'h0);
    if (hready !== 1'b1) tally_and_finish();
  endtask
  task automatic expect_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(q & m, e);
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: return seen[0];
      1: return seen[1];
      default: return seen[2];
    endcase
  endfunction
  task automatic await(input int k, input logic v, input int lim);
    int n;
    n = 0;
    while (pick(k) !== v && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    check({31'h0, pick(k)}, {31'h0, v});
    if (pick(k) !== v) tally_and_finish();
  endtask
  // Every enabled wake input must be idle before this is called
  task automatic to_backup();
    bus(1'b1, 8'h00, 32'h4);
    await(1, 1'b0, 10);
  endtask
  task automatic revive();
    await(1, 1'b1, 8);
    calendarAlarm <= 1'b0;
    intervalAlarm <= 1'b0;
    force_wake_pin_n <= 1'b1;
    await(0, 1'b1, 40);
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    expect_reg(8'h08, 32'hffff_ffff, 32'h0000_5000);
    expect_reg(8'h0c, 32'hffff_ffff, 32'h0);
    expect_reg(8'h1c, 32'hffff_ffff, 32'h0);
    await(0, 1'b1, 40);
    bus(1'b1, 8'h04, 32'h0000_1000);
    monitorDetect <= 1'b1;
    await(0, 1'b0, 4);
    monitorDetect <= 1'b0;
    await(0, 1'b1, 40);
    expect_reg(8'h14, 32'h10, 32'h10);
    repeat (3) @(posedge ref_clk);
    expect_reg(8'h14, 32'h10, 32'h0);
    bus(1'b1, 8'h18, 32'h1);
    bus(1'b1, 8'h04, 32'h0);
    bus(1'b1, 8'h00, 32'h4);
    expect_reg(8'h04, 32'hffff_ffff, 32'h0000_1000);
    check({31'h0, pick(1)}, 32'h1);
    bus(1'b1, 8'h18, 32'h0);
    bus(1'b1, 8'h04, 32'h0);
    expect_reg(8'h04, 32'hffff_ffff, 32'h0);
    dropGood <= 1'b1;
    @(posedge ref_clk);
    dropGood <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check({31'h0, pick(0)}, 32'h1);
    dropGood <= 1'b1;
    await(0, 1'b0, 5);
    repeat (6) @(posedge ref_clk);
    check({31'h0, pick(0)}, 32'h0);
    dropGood <= 1'b0;
    await(0, 1'b1, 10);
    expect_reg(8'h14, 32'h8, 32'h8);
    // Tamper input 0 pulses backup clear and sets the tamper0 flag, not tamper1
    bus(1'b1, 8'h0c, 32'h0152_0000);
    pulseRun <= 1'b1;
    wake_input_n[0] <= 1'b1;
    await(2, 1'b1, 40);
    expect_reg(8'h14, 32'h180, 32'h080);
    wake_input_n[0] <= 1'b0;
    pulseRun <= 1'b0;
    bus(1'b1, 8'h10, 32'h0008_000c);
    bus(1'b1, 8'h0c, 32'h0000_1000);
    to_backup();
    wake_input_n[2] <= 1'b0;
    revive();
    wake_input_n[2] <= 1'b1;
    expect_reg(8'h14, 32'h000c_0002, 32'h0004_0002);
    for (int k = 0; k < 6; k++) begin
      bus(1'b1, 8'h0c, 32'h1 | (32'(k) << 8));
      to_backup();
      if (dbc[k] > 1) begin
        force_wake_pin_n <= 1'b0;
        repeat (dbc[k] - 1) @(posedge ref_clk);
        force_wake_pin_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        check({31'h0, pick(1)}, 32'h0);
      end
      force_wake_pin_n <= 1'b0;
      repeat (dbc[k]) @(posedge ref_clk);
      revive();
      expect_reg(8'h14, 32'h1, 32'h1);
    end
    bus(1'b1, 8'h0c, 32'h0000_000c);
    to_backup();
    calendarAlarm <= 1'b1;
    revive();
    to_backup();
    intervalAlarm <= 1'b1;
    revive();
    tally_and_finish();
  end
endmodule // test_crw_core_reset_wake
